// file: common/copy_base_defs.vh
// constants for the copy base setup command decoder
// assumes 32-bit command dwords from the video command streamer
`ifndef COPY_BASE_DEFS_VH
`define COPY_BASE_DEFS_VH

// header dword 0 fields
`define CB_TYPE_HI          31
`define CB_TYPE_LO          29
`define CB_TYPE_VIDEO       3'h3
`define CB_PIPE_HI          28
`define CB_PIPE_LO          27
`define CB_PIPE_BSDEC       2'h2
`define CB_OPC_HI           26
`define CB_OPC_LO           24
`define CB_OPC_CRYPTO       3'h6
`define CB_SUB_HI           23
`define CB_SUB_LO           16
`define CB_SUB_BASE         8'h00
`define CB_LEN_HI           15
`define CB_LEN_LO           0
`define CB_LEN_VAL          16'h0002

// address dword fields
`define CB_ADDR_HI          31
`define CB_ADDR_LO          12
`define CB_ADDR_RST         20'h00000

// register port offsets
`define CB_REG_SRC_BASE     4'h0
`define CB_REG_LIMIT        4'h1
`define CB_REG_DST_BASE     4'h2
`define CB_REG_STATUS       4'h3
`define CB_REG_CTRL         4'h4

`endif

// file: hw/bound_mask.v
// bound check and zero substitution for returned source fetch data
// assumes fetch address and data arrive together on the engine clock
`timescale 1ns/10ps
`include "copy_base_defs.vh"
module bound_mask #(
	parameter DW = 32
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          rst_n_i,
	// bound state
	input  wire [19:0]   limit_i,
	input  wire          indirect_i,
	// returned data
	input  wire          rd_valid_i,
	input  wire [31:0]   rd_addr_i,
	input  wire [DW-1:0] rd_data_i,
	output reg           out_valid_o,
	output reg  [DW-1:0] out_data_o,
	output reg           out_zeroed_o
);
	wire check_on;
	wire beyond;

	// zero limit or no indirect data switches checking off
	assign check_on = (limit_i != `CB_ADDR_RST) && indirect_i;
	assign beyond   = check_on && (rd_addr_i[`CB_ADDR_HI:`CB_ADDR_LO] >= limit_i);

	// request was already issued; only the returned data is masked
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			out_valid_o  <= 1'b0;
			out_data_o   <= {DW{1'b0}};
			out_zeroed_o <= 1'b0;
		end else begin
			out_valid_o  <= rd_valid_i;
			out_zeroed_o <= rd_valid_i && beyond;
			out_data_o   <= beyond ? {DW{1'b0}} : rd_data_i;
		end
	end
endmodule // bound_mask

// file: hw/crypto_copy_base_addr_state.v
// decoder and state holder for the copy base setup command
// assumes the streamer hands over one dword per valid cycle, header first
//
// Notes on behaviour
// - header top bits must be video pipe type
// - pipeline, opcode, sub-opcode identify this command
// - length field must equal two, four dwords
// - dword one high bits give source base
// - dword three high bits give destination base
// - bases always added to copy start addresses
// - dword two high bits give exclusive limit
// - fetches at or above limit return zero
// - out-of-bound requests still go to memory
// - zero limit disables range check
// - disabled limit passes returned data unchanged
// - limit ignored without indirect data
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "copy_base_defs.vh"
module crypto_copy_base_addr_state #(
	parameter DW = 32
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          rst_n_i,
	// command dwords from the streamer
	input  wire          cmd_valid_i,
	input  wire [31:0]   cmd_dword_i,
	input  wire          cmd_first_i,
	// copy command start offsets and fetch path
	input  wire          indirect_i,
	input  wire [31:0]   src_start_i,
	input  wire [31:0]   dst_start_i,
	input  wire          rd_valid_i,
	input  wire [31:0]   rd_addr_i,
	input  wire [DW-1:0] rd_data_i,
	// register port
	input  wire [3:0]    reg_addr_i,
	input  wire [31:0]   reg_wdata_i,
	input  wire          reg_wr_i,
	input  wire          reg_rd_i,
	output reg  [31:0]   reg_rdata_o,
	// results
	output reg  [31:0]   src_addr_o,
	output reg  [31:0]   dst_addr_o,
	output reg           cmd_done_o,
	output reg           cmd_error_o,
	output wire          out_valid_o,
	output wire [DW-1:0] out_data_o,
	output wire          out_zeroed_o
);
	// data flow: the header is checked field by field, the first two payload
	// dwords go into hold registers, and all three values are committed
	// together at the third; the stored values then feed the address sums
	// and the fetch mask until the next good command or an engine reset;
	// nothing here ever stalls the streamer, so there is no back-pressure

	// walk states, one-hot; a stray code falls back to idle
	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_SRC  = 4'h2;
	localparam [3:0] S_LIM  = 4'h4;
	localparam [3:0] S_DST  = 4'h8;

	// walk state
	reg  [3:0]  state_ff;
	reg  [3:0]  nxt_state;
	// committed engine state read by the later copy
	reg  [19:0] src_base_ff;
	reg  [19:0] limit_ff;
	reg  [19:0] dst_base_ff;
	// payload held until the last dword lands
	reg  [19:0] src_hold_ff;
	reg  [19:0] lim_hold_ff;
	// software control and bookkeeping
	reg         check_en_ff;
	reg  [7:0]  accept_cnt_ff;
	reg  [7:0]  reject_cnt_ff;
	// read data before its register
	reg  [31:0] nxt_rdata;
	// header fields
	wire [2:0]  hdr_type;
	wire [1:0]  hdr_pipe;
	wire [2:0]  hdr_opc;
	wire [7:0]  hdr_sub;
	wire [15:0] hdr_len;
	// header field matches
	wire        type_ok;
	wire        pipe_ok;
	wire        opc_ok;
	wire        sub_ok;
	wire        len_ok;
	wire        hdr_ok;
	wire        take_hdr;
	wire        hdr_bad;
	// payload strobes
	wire        take_pay;
	wire        take_src;
	wire        take_lim;
	wire        take_dst;
	wire [19:0] pay_addr;
	// register port decode
	wire        ctrl_wr;
	wire [31:0] status_word;
	// address sums
	wire [31:0] src_sum;
	wire [31:0] dst_sum;
	// masking control
	wire        mask_indirect;

	// header slices; together the five fields cover all of dword 0
	assign hdr_type = cmd_dword_i[`CB_TYPE_HI:`CB_TYPE_LO];
	assign hdr_pipe = cmd_dword_i[`CB_PIPE_HI:`CB_PIPE_LO];
	assign hdr_opc  = cmd_dword_i[`CB_OPC_HI:`CB_OPC_LO];
	assign hdr_sub  = cmd_dword_i[`CB_SUB_HI:`CB_SUB_LO];
	assign hdr_len  = cmd_dword_i[`CB_LEN_HI:`CB_LEN_LO];

	// each field compared on its own so a refused header is easy to trace
	assign type_ok = (hdr_type == `CB_TYPE_VIDEO);
	assign pipe_ok = (hdr_pipe == `CB_PIPE_BSDEC);
	assign opc_ok  = (hdr_opc == `CB_OPC_CRYPTO);
	assign sub_ok  = (hdr_sub == `CB_SUB_BASE);
	assign len_ok  = (hdr_len == `CB_LEN_VAL);

	// a header needs every field right; the key-exchange command
	// differs only in its sub-opcode and length, so both are checked
	assign hdr_ok   = type_ok && pipe_ok && opc_ok && sub_ok && len_ok;
	assign take_hdr = cmd_valid_i && cmd_first_i;
	assign hdr_bad  = take_hdr && !hdr_ok;

	// payload dwords count only without the first flag, in walk order
	assign take_pay = cmd_valid_i && !cmd_first_i;
	assign take_src = take_pay && (state_ff == S_SRC);
	assign take_lim = take_pay && (state_ff == S_LIM);
	assign take_dst = take_pay && (state_ff == S_DST);

	// reserved low bits are dropped here and never reach stored state
	assign pay_addr = cmd_dword_i[`CB_ADDR_HI:`CB_ADDR_LO];

	// payload walk; a new header always restarts the walk
	// and a refused header parks it, so its payload falls on idle
	always @* begin
		nxt_state = state_ff;
		if (take_hdr) begin
			nxt_state = hdr_ok ? S_SRC : S_IDLE;
		end else if (cmd_valid_i) begin
			case (state_ff)
				S_SRC:   nxt_state = S_LIM;
				S_LIM:   nxt_state = S_DST;
				S_DST:   nxt_state = S_IDLE;
				S_IDLE:  nxt_state = S_IDLE;
				default: nxt_state = S_IDLE;
			endcase
		end
	end

	// walk state register; reset parks the walk on idle
	// so a payload dword after reset is ignored
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_ff <= S_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// payload hold; a cut command only ever touches these,
	// so a header in mid-walk leaves the stored values in force
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			src_hold_ff <= `CB_ADDR_RST;
			lim_hold_ff <= `CB_ADDR_RST;
		end else begin
			if (take_src) begin
				src_hold_ff <= pay_addr;
			end
			if (take_lim) begin
				lim_hold_ff <= pay_addr;
			end
		end
	end

	// committed state changes all at once with the last dword,
	// so a copy never pairs a new base with an old limit
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			src_base_ff <= `CB_ADDR_RST;
			limit_ff    <= `CB_ADDR_RST;
			dst_base_ff <= `CB_ADDR_RST;
		end else if (take_dst) begin
			src_base_ff <= src_hold_ff;
			limit_ff    <= lim_hold_ff;
			dst_base_ff <= pay_addr;
		end
	end

	// one-cycle result pulses for the streamer;
	// a refused header answers one cycle after it is taken
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			cmd_done_o  <= 1'b0;
			cmd_error_o <= 1'b0;
		end else begin
			cmd_done_o  <= take_dst;
			cmd_error_o <= hdr_bad;
		end
	end

	// event counters wrap at 255;
	// software should read differences, not totals
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			accept_cnt_ff <= 8'h00;
			reject_cnt_ff <= 8'h00;
		end else begin
			if (take_dst) begin
				accept_cnt_ff <= accept_cnt_ff + 8'h01;
			end
			if (hdr_bad) begin
				reject_cnt_ff <= reject_cnt_ff + 8'h01;
			end
		end
	end

	// control register decode; only the check enable bit is kept
	assign ctrl_wr = reg_wr_i && (reg_addr_i == `CB_REG_CTRL);

	// check enable resets on, so masking works without a setup write;
	// clearing it is a debug aid that exposes beyond-bound data
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			check_en_ff <= 1'b1;
		end else if (ctrl_wr) begin
			check_en_ff <= reg_wdata_i[0];
		end
	end

	// bases are always added; zero bases make the offsets plain addresses
	// the sums wrap at the top of the 32-bit space, offsets are not range checked
	assign src_sum = {src_base_ff, 12'h000} + src_start_i;
	assign dst_sum = {dst_base_ff, 12'h000} + dst_start_i;

	// address registers follow the start offsets one cycle later,
	// so the copy sees base and offset from the same edge
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			src_addr_o <= 32'h00000000;
			dst_addr_o <= 32'h00000000;
		end else begin
			src_addr_o <= src_sum;
			dst_addr_o <= dst_sum;
		end
	end

	// status word: reject count, accept count and the walk state;
	// the counts are eight bits and roll over silently
	assign status_word = {8'h00, reject_cnt_ff, accept_cnt_ff, 4'h0, state_ff};

	// read mux; unmapped offsets and idle cycles give zero,
	// writes have no side effect here other than the control bit
	always @* begin
		nxt_rdata = 32'h00000000;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`CB_REG_SRC_BASE: nxt_rdata = {src_base_ff, 12'h000};
				`CB_REG_LIMIT:    nxt_rdata = {limit_ff, 12'h000};
				`CB_REG_DST_BASE: nxt_rdata = {dst_base_ff, 12'h000};
				`CB_REG_STATUS:   nxt_rdata = status_word;
				`CB_REG_CTRL:     nxt_rdata = {31'h00000000, check_en_ff};
				default:          nxt_rdata = 32'h00000000;
			endcase
		end
	end

	// read data stand one cycle after the strobe and only then
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h00000000;
		end else begin
			reg_rdata_o <= nxt_rdata;
		end
	end

	// debug switch can only turn masking off, never widen it
	assign mask_indirect = indirect_i && check_en_ff;

	// fetch data masking against the stored limit
	bound_mask #(
		.DW (DW)
	) u_mask (
		.clk_i        (clk_i),
		.rst_n_i      (rst_n_i),
		.limit_i      (limit_ff),
		.indirect_i   (mask_indirect),
		.rd_valid_i   (rd_valid_i),
		.rd_addr_i    (rd_addr_i),
		.rd_data_i    (rd_data_i),
		.out_valid_o  (out_valid_o),
		.out_data_o   (out_data_o),
		.out_zeroed_o (out_zeroed_o)
	);
endmodule // crypto_copy_base_addr_state

// file: test/cmd_streamer_model.sv
// streamer model: sends a four-dword command after go_i
// assumes go_i is pulsed only while idle
`timescale 1ns/10ps
module cmd_streamer_model (
	// control
	input  wire         clk_i,
	input  wire         go_i,
	input  wire [127:0] cmd_i,
	// dwords, header first
	output wire         cmd_valid_o,
	output wire [31:0]  cmd_dword_o,
	output wire         cmd_first_o
);
	reg [2:0] idx_ff = 3'h4;
	// idle line shows an inverse so a stale dword never passes for live data
	always @(posedge clk_i) idx_ff <= go_i ? 3'h0 : idx_ff + {2'h0, idx_ff != 3'h4};
	assign cmd_valid_o = idx_ff != 3'h4;
	assign cmd_first_o = idx_ff == 3'h0;
	assign cmd_dword_o = cmd_valid_o ? cmd_i[{idx_ff[1:0], 5'h00} +: 32] : ~cmd_i[127:96];
endmodule // cmd_streamer_model

// file: test/crypto_copy_base_addr_state_props.sv
// header and fetch checks for the copy base setup decoder
// assumes one engine clock with synchronous active-low reset
`timescale 1ns/10ps
module crypto_copy_base_addr_state_props #(
	parameter DW = 32
) (
	input wire          clk_i,
	input wire          rst_n_i,
	input wire          cmd_valid_i,
	input wire [31:0]   cmd_dword_i,
	input wire          cmd_first_i,
	input wire          indirect_i,
	input wire          rd_valid_i,
	input wire [DW-1:0] rd_data_i,
	input wire          out_valid_o,
	input wire [DW-1:0] out_data_o,
	input wire          out_zeroed_o,
	input wire          cmd_done_o,
	input wire          cmd_error_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire hd = cmd_valid_i && cmd_first_i;
	property p_type; hd && cmd_dword_i[31:29] != 3'h3 |=> cmd_error_o; endproperty
	a_type: assert property (p_type) else $error("bad type kept");
	property p_opc; hd && cmd_dword_i[28:16] != 13'h1600 |=> cmd_error_o; endproperty
	a_opc: assert property (p_opc) else $error("bad opcode kept");
	property p_len; hd && cmd_dword_i[15:0] != 16'h0002 |=> cmd_error_o; endproperty
	a_len: assert property (p_len) else $error("bad length kept");
	property p_good; hd && cmd_dword_i == 32'h7600_0002 |=> !cmd_error_o; endproperty
	a_good: assert property (p_good) else $error("good header refused");
	property p_fetch; rd_valid_i |=> out_valid_o; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch dropped");
	property p_pass; rd_valid_i && !indirect_i |=> out_data_o == $past(rd_data_i); endproperty
	a_pass: assert property (p_pass) else $error("direct data changed");
	property p_zero; out_zeroed_o |-> out_valid_o && out_data_o == '0; endproperty
	a_zero: assert property (p_zero) else $error("zeroed data nonzero");
	property p_done; cmd_done_o |-> $past(cmd_valid_i) && !$past(cmd_first_i); endproperty
	a_done: assert property (p_done) else $error("done without dword");
endmodule // crypto_copy_base_addr_state_props
bind crypto_copy_base_addr_state crypto_copy_base_addr_state_props #(.DW(DW)) props (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_dword_i(cmd_dword_i),
	.cmd_first_i(cmd_first_i), .indirect_i(indirect_i), .rd_valid_i(rd_valid_i),
	.rd_data_i(rd_data_i), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
	.out_zeroed_o(out_zeroed_o), .cmd_done_o(cmd_done_o), .cmd_error_o(cmd_error_o));

// file: test/tb_top.sv
// testbench for the copy base setup decoder
// assumes the streamer model and the checker are compiled first
`timescale 1ns/10ps
module tb_top;
	localparam [159:0] bad_hdr = 160'h7600_0003_7601_0002_7700_0002_6E00_0002_5600_0002;
	reg          clk = 1'b0, rst_n = 1'b0, go = 1'b0, ind = 1'b1, rv = 1'b0, wr = 1'b0, rd = 1'b0;
	reg  [127:0] cmd = 128'h0;
	reg  [31:0]  ra = 32'h0, rdd = 32'h0, st = 32'h0, wd = 32'h0;
	reg  [3:0]   a = 4'h0;
	wire [31:0]  dw, rdata, sa, da, od;
	wire         v, f, done, err, ov, z;
	integer      error_cnt = 0, n_tests = 0, i;
	always #50 clk = ~clk;
	cmd_streamer_model streamer (.clk_i(clk), .go_i(go), .cmd_i(cmd), .cmd_valid_o(v),
		.cmd_dword_o(dw), .cmd_first_o(f));
	crypto_copy_base_addr_state uut (.clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(v),
		.cmd_dword_i(dw), .cmd_first_i(f), .indirect_i(ind), .src_start_i(st), .dst_start_i(st),
		.rd_valid_i(rv), .rd_addr_i(ra), .rd_data_i(rdd), .reg_addr_i(a), .reg_wdata_i(wd),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .src_addr_o(sa), .dst_addr_o(da),
		.cmd_done_o(done), .cmd_error_o(err), .out_valid_o(ov), .out_data_o(od), .out_zeroed_o(z));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// every clocked task starts just after a rising edge and returns just after one
	task rreg(input [3:0] ad, input [31:0] exp);
		begin
			a <= ad;
			rd <= 1'b1;
			@(posedge clk) rd <= 1'b0;
			@(negedge clk) chk(rdata, exp);
			@(posedge clk);
		end
	endtask
	task wreg(input [3:0] ad, input [31:0] d);
		begin
			a <= ad;
			wd <= d;
			wr <= 1'b1;
			@(posedge clk) wr <= 1'b0;
		end
	endtask
	task fetch(input [31:0] ad, input [31:0] d, input [31:0] exp, input ez);
		begin
			ra <= ad;
			rdd <= d;
			rv <= 1'b1;
			@(posedge clk) rv <= 1'b0;
			rdd <= ~d; // released bus never repeats the last word
			@(negedge clk) chk({31'h0, ov}, 32'h1);
			chk(od, exp);
			chk({31'h0, z}, {31'h0, ez});
			@(posedge clk);
		end
	endtask
	task send(input [127:0] c, input e);
		begin
			cmd <= c;
			go <= 1'b1;
			@(posedge clk) go <= 1'b0;
			@(posedge clk);
			@(negedge clk) chk({31'h0, err}, {31'h0, e});
			repeat (3) @(posedge clk);
			@(negedge clk) chk({31'h0, done}, {31'h0, ~e});
			@(posedge clk);
		end
	endtask
	task finish_test;
		begin
			$display("compares %0d mismatches %0d", n_tests, error_cnt);
			if (error_cnt == 0 && n_tests > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		#200000;
		error_cnt = error_cnt + 1;
		finish_test;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 3; i = i + 1) rreg(i[3:0], 32'h0);
		rreg(4'h3, 32'h0000_0001);
		rreg(4'h4, 32'h1);
		rreg(4'hF, 32'h0);
		st <= 32'h0000_0040;
		@(posedge clk);
		@(negedge clk) chk(sa, 32'h0000_0040);
		chk(da, 32'h0000_0040);
		@(posedge clk);
		fetch(32'h7000_0000, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 1'b0);
		$display("reset test end");
		send({32'h0003_0123, 32'h0002_0FFF, 32'h0001_0ABC, 32'h7600_0002}, 1'b0);
		rreg(4'h0, 32'h0001_0000);
		rreg(4'h1, 32'h0002_0000);
		rreg(4'h2, 32'h0003_0000);
		st <= 32'h0000_0040;
		@(posedge clk);
		@(negedge clk) chk(sa, 32'h0001_0040);
		chk(da, 32'h0003_0040);
		@(posedge clk);
		fetch(32'h0001_FFFC, 32'h1234_5678, 32'h1234_5678, 1'b0);
		fetch(32'h0002_0000, 32'h1234_5678, 32'h0, 1'b1);
		ind <= 1'b0;
		fetch(32'h0002_0000, 32'h1234_5678, 32'h1234_5678, 1'b0);
		ind <= 1'b1;
		$display("capture test end");
		for (i = 0; i < 5; i = i + 1) send({96'hFFFF_F000, bad_hdr[i*32 +: 32]}, 1'b1);
		rreg(4'h1, 32'h0002_0000);
		rreg(4'h3, 32'h0005_0101);
		wreg(4'h4, 32'h0);
		rreg(4'h4, 32'h0);
		fetch(32'h0002_0000, 32'h0BAD_F00D, 32'h0BAD_F00D, 1'b0);
		$display("reject test end");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rreg(4'h1, 32'h0);
		rreg(4'h4, 32'h1);
		$display("second reset test end");
		finish_test;
	end
endmodule // tb_top
